// ### rtl/serial_eeprom_rw_engine.sv
// Two-wire serial EEPROM target: writes, reads, programming cycle
`timescale 1ns/1ps
module serial_eeprom_rw_engine
	import eeprom_pkg::*;
#(
	parameter int density_kbit = density_kbit_dflt,
	parameter int program_cycles = program_cycle_dflt
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [2:0] chip_select_inputs,
	input wire logic write_protect,
	output logic busy
);
	// Density-derived geometry
	localparam int aw = (density_kbit == 2) ? 8 : (density_kbit == 4) ? 9 :
		(density_kbit == 8) ? 10 : 11;
	localparam int pbits = (density_kbit == 2) ? 3 : 4;
	localparam int page_bytes = 1 << pbits;
	localparam int xbits = aw - 8;
	localparam int cw = $clog2(program_cycles + 1);

	logic [1:0] pins;
	logic scl, sda, scl_d_r, sda_d_r;
	logic start_ev, stop_ev, scl_rise, scl_fall;
	eep_state_t state_r;
	logic [3:0] bit_r;
	logic [7:0] shift_r;
	logic ack_phase_r;
	logic [aw-1:0] addr_r;
	logic [2:0] dev_hi_r;
	logic wrote_r;
	logic nack_r;
	logic [cw-1:0] prog_cnt_r;
	logic [7:0] pbuf_r [0:page_buf_max-1];
	logic [page_buf_max-1:0] pvalid_r;
	logic [aw-1:0] page_base_r;
	logic [pbits-1:0] flush_idx_r;
	logic mem_we;
	logic [7:0] rdata;
	logic [aw-1:0] raddr;
	logic dev_match;
	logic [7:0] out_byte_r;
	logic sda_drv_r;

	// Next address inside the page, upper bits kept
	function automatic logic [aw-1:0] page_inc(input logic [aw-1:0] a);
		page_inc = {a[aw-1:pbits], a[pbits-1:0] + 1'b1};
	endfunction : page_inc

	// Next address over the whole array, wrapping to zero
	function automatic logic [aw-1:0] full_inc(input logic [aw-1:0] a);
		full_inc = a + 1'b1;
	endfunction : full_inc

	bus_sync #(.w(2)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.d({scl_in, sda_in}),
		.q(pins)
	);
	assign scl = pins[1];
	assign sda = pins[0];

	// Edge history of the synchronised pins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl;
			sda_d_r <= sda;
		end
	end

	// Bus conditions; ignored while programming
	assign start_ev = scl && scl_d_r && sda_d_r && !sda && state_r != st_busy;
	assign stop_ev = scl && scl_d_r && !sda_d_r && sda && state_r != st_busy;
	assign scl_rise = scl && !scl_d_r;
	assign scl_fall = !scl && scl_d_r;

	// Device byte compare: type code then select bits by density
	always_comb begin
		dev_match = shift_r[7:4] == dev_type_code;
		if (density_kbit == 2) begin
			dev_match = dev_match && shift_r[3:1] == chip_select_inputs;
		end else if (density_kbit == 4) begin
			dev_match = dev_match && shift_r[3:2] == chip_select_inputs[2:1];
		end else if (density_kbit == 8) begin
			dev_match = dev_match && shift_r[3] == chip_select_inputs[2];
		end
	end

	// Protocol state machine and bit counter
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= st_idle;
			bit_r <= 4'h0;
			shift_r <= 8'h00;
			ack_phase_r <= 1'b0;
			nack_r <= 1'b0;
		end else if (state_r == st_busy) begin
			if (prog_cnt_r == '0 && flush_idx_r == '0 && pvalid_r == '0) begin
				state_r <= st_idle;
			end
		end else if (start_ev) begin
			state_r <= st_dev;
			bit_r <= 4'h0;
			ack_phase_r <= 1'b0;
		end else if (stop_ev) begin
			state_r <= (wrote_r && !write_protect) ? st_busy : st_idle;
		end else if (scl_rise && !ack_phase_r && state_r != st_idle) begin
			shift_r <= {shift_r[6:0], sda};
			bit_r <= bit_r + 4'h1;
		end else if (scl_rise && ack_phase_r && state_r == st_rack) begin
			nack_r <= sda;
		end else if (scl_fall && bit_r == 4'h8 && !ack_phase_r) begin
			ack_phase_r <= 1'b1;
			bit_r <= 4'h0;
			unique case (state_r)
				st_dev: state_r <= dev_match ? st_dev : st_idle;
				st_rdata: state_r <= st_rack;
				default: state_r <= state_r;
			endcase
		end else if (scl_fall && ack_phase_r) begin
			ack_phase_r <= 1'b0;
			unique case (state_r)
				st_dev: state_r <= shift_r[0] ? st_rdata : st_word;
				st_word: state_r <= st_wdata;
				st_wdata: state_r <= st_wdata;
				st_rack: state_r <= nack_r ? st_idle : st_rdata;
				default: state_r <= state_r;
			endcase
		end
	end

	// Address counter, retained across transfers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addr_r <= '0;
			dev_hi_r <= 3'h0;
			wrote_r <= 1'b0;
		end else if (start_ev) begin
			wrote_r <= 1'b0;
		end else if (stop_ev) begin
			wrote_r <= 1'b0;
		end else if (scl_fall && bit_r == 4'h8 && !ack_phase_r) begin
			unique case (state_r)
				st_dev: dev_hi_r <= shift_r[3:1];
				st_word: begin
					if (xbits > 0) begin
						addr_r <= aw'({dev_hi_r, shift_r});
					end else begin
						addr_r <= aw'(shift_r);
					end
				end
				st_wdata: begin
					addr_r <= page_inc(addr_r);
					wrote_r <= 1'b1;
				end
				st_rdata: addr_r <= full_inc(addr_r);
				default: addr_r <= addr_r;
			endcase
		end
	end

	// Page buffer collects bytes, later bytes overwrite earlier
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pvalid_r <= '0;
			page_base_r <= '0;
			flush_idx_r <= '0;
		end else if (state_r == st_busy) begin
			if (pvalid_r[flush_idx_r]) begin
				pvalid_r[flush_idx_r] <= 1'b0;
			end
			flush_idx_r <= flush_idx_r + 1'b1;
		end else if (state_r == st_word) begin
			pvalid_r <= '0;
		end else if (state_r == st_wdata && scl_fall && bit_r == 4'h8 &&
			!ack_phase_r) begin
			pvalid_r[addr_r[pbits-1:0]] <= 1'b1;
			page_base_r <= {addr_r[aw-1:pbits], {pbits{1'b0}}};
		end
	end

	// Page buffer data
	always_ff @(posedge clk) begin
		if (state_r == st_wdata && scl_fall && bit_r == 4'h8 && !ack_phase_r) begin
			pbuf_r[addr_r[pbits-1:0]] <= shift_r;
		end
	end

	// Programming timer; bus ignored until it expires
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prog_cnt_r <= '0;
		end else if (stop_ev && wrote_r && !write_protect) begin
			prog_cnt_r <= cw'(program_cycles);
		end else if (prog_cnt_r != '0) begin
			prog_cnt_r <= prog_cnt_r - 1'b1;
		end
	end

	// Writes to the array only while programming; protect is sampled only at the closing stop
	assign mem_we = state_r == st_busy && pvalid_r[flush_idx_r];
	// Array read always follows the address counter
	assign raddr = addr_r;

	eep_array #(.aw(aw)) u_array (
		.clk(clk),
		.we(mem_we),
		.waddr(page_base_r | aw'(flush_idx_r)),
		.wdata(pbuf_r[flush_idx_r]),
		.raddr(raddr),
		.rdata(rdata)
	);

	// Load outgoing byte at the start of each read byte
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			out_byte_r <= 8'hff;
		end else if (state_r == st_rdata && bit_r == 4'h0 && !scl && !ack_phase_r) begin
			out_byte_r <= rdata;
		end else if (state_r == st_rdata && scl_fall && bit_r != 4'h0) begin
			out_byte_r <= {out_byte_r[6:0], 1'b1};
		end
	end

	// Open-drain drive: ack low on ninth clock, read data bits
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sda_drv_r <= 1'b0;
		end else if (start_ev || stop_ev || state_r == st_busy) begin
			sda_drv_r <= 1'b0;
		end else if (!scl) begin
			if (ack_phase_r && state_r inside {st_dev, st_word, st_wdata}) begin
				sda_drv_r <= 1'b1;
			end else if (state_r == st_rdata && !ack_phase_r && bit_r < 4'h8) begin
				sda_drv_r <= (bit_r == 4'h0) ? !rdata[7] : !out_byte_r[7];
			end else begin
				sda_drv_r <= 1'b0;
			end
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = sda_drv_r;
	assign busy = state_r == st_busy;
endmodule : serial_eeprom_rw_engine

// ### common/eeprom_pkg.sv
// Constants shared by the serial EEPROM engine
// Notes on behaviour
// - Word address byte follows device address, acknowledged
// - Byte write acked, controller then stops
// - After write stop, timed cycle ignores bus
// - Page is 8 or 16 bytes
// - Every page write data byte is acknowledged
// - Only low page bits increment on writes
// - Page boundary wraps to same page start
// - Poll acknowledged only after programming ends
// - Read starts like write with bit set
// - Address counter holds last address plus one
// - Read increment wraps end to start
// - Current read sends byte at counter
// - After restart, send byte at loaded address
// - Controller ack advances to next byte
// - Sequential read wraps without interruption
// - Program time counts from closing stop
// - Device byte: four-bit type, three select bits
// - Page bits extend word address on large parts
// - Ack drives data low on ninth clock
// - Protect input high blocks all array writes; engine samples it only at the closing stop
package eeprom_pkg;
	localparam logic [3:0] dev_type_code = 4'ha;
	localparam int density_kbit_dflt = 2;
	localparam int program_cycle_time_ns = 5000000;
	localparam int clk_period_ns = 10;
	localparam int program_cycle_dflt = program_cycle_time_ns / clk_period_ns;
	localparam int page_buf_max = 16;

	typedef enum logic [2:0] {
		st_idle, st_dev, st_word, st_wdata, st_rdata, st_rack, st_busy
	} eep_state_t;
endpackage : eeprom_pkg

// ### rtl/eep_array.sv
// Byte-wide storage array with registered read data
`timescale 1ns/1ps
module eep_array #(
	parameter int aw = 8
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [aw-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [aw-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:(1<<aw)-1];

	// Write port and registered read port
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : eep_array

// ### rtl/bus_sync.sv
// Two-stage synchroniser for the bus pins
`timescale 1ns/1ps
module bus_sync #(
	parameter int w = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [w-1:0] d,
	output logic [w-1:0] q
);
	logic [w-1:0] meta_r;

	// Idle bus is high
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= '1;
			q <= '1;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : bus_sync

// ### verif/eep_properties.sv
// Port checks for the serial EEPROM engine
`timescale 1ns/1ps
module eep_properties #(
	parameter int program_cycles = 50
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [2:0] chip_select_inputs,
	input wire logic write_protect,
	input wire logic busy
);
	int cnt_r;
	// Cycles spent programming
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			cnt_r <= 0;
		else
			cnt_r <= busy ? cnt_r + 1 : 0;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_stop; scl_in && sda_in; endsequence
	sequence s_hold; busy [*8]; endsequence
	property p_od; sda_out == 1'b0; endproperty
	property p_quiet; busy |-> !sda_oe; endproperty
	property p_edge; $changed(sda_oe) |-> !scl_in; endproperty
	property p_rel; $rose(sda_oe) |-> ##[1:300] !sda_oe; endproperty
	property p_stop; $rose(busy) |-> s_stop; endproperty
	property p_hold; $rose(busy) |-> s_hold; endproperty
	property p_len; $fell(busy) |-> cnt_r >= program_cycles; endproperty
	property p_wp; $rose(busy) |-> !write_protect; endproperty
	a_od: assert property (p_od) else $error("sda_out high");
	a_quiet: assert property (p_quiet) else $error("drive while busy");
	a_edge: assert property (p_edge) else $error("sda moved, scl high");
	a_rel: assert property (p_rel) else $error("sda held too long");
	a_stop: assert property (p_stop) else $error("busy without stop");
	a_hold: assert property (p_hold) else $error("busy too short");
	a_len: assert property (p_len) else $error("cycle too short");
	a_wp: assert property (p_wp) else $error("protected write ran");
endmodule : eep_properties

bind serial_eeprom_rw_engine eep_properties #(
	.program_cycles(program_cycles)
) eep_properties_inst (
	.clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .busy(busy),
	.chip_select_inputs(chip_select_inputs),
	.write_protect(write_protect)
);

// ### verif/ctl_model.sv
// Bus controller model driving the two-wire pins
`timescale 1ns/1ps
module ctl_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	initial scl = 1'b1;
	initial sda_low = 1'b0;
	// One bus phase of ten clocks
	task automatic hold();
		repeat (10) @(posedge clk);
	endtask : hold
	// Start or repeated start; clock stands high when idle
	task automatic start();
		if (!scl) begin
			sda_low <= 1'b0;
			hold();
			scl <= 1'b1;
			hold();
		end
		sda_low <= 1'b1;
		hold();
		scl <= 1'b0;
		hold();
	endtask : start
	// Byte out MSB first, ninth bit released or acked
	task automatic xfer(input logic [7:0] d, input logic rel,
		output logic [7:0] q, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_low <= (i > 0) ? !d[i-1] : !rel;
			hold();
			scl <= 1'b1;
			hold();
			// SDA only moves while SCL is low, so it is settled here
			if (i > 0)
				q[i-1] = sda;
			else
				ack = sda;
			scl <= 1'b0;
			hold();
		end
	endtask : xfer
	// Stop; line then idles high
	task automatic stop();
		sda_low <= 1'b1;
		hold();
		scl <= 1'b1;
		hold();
		sda_low <= 1'b0;
		hold();
	endtask : stop
endmodule : ctl_model

// ### verif/serial_eeprom_rw_engine_tb.sv
// Self-checking bench for the serial EEPROM engine
`timescale 1ns/1ps
module serial_eeprom_rw_engine_tb
	import eeprom_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic write_protect = 1'b0;
	logic [2:0] chip_select_inputs = 3'h5;
	logic scl, sda_low, sda, sda_out, sda_oe, busy;
	logic [7:0] mem [256];
	logic [7:0] cnt_e = 8'h00;
	logic [7:0] dw, dr, q;
	logic k;
	int err_total = 0;
	int checked = 0;
	int cyc = 0;
	// Device bytes and open-drain line with pull-up
	assign dw = {dev_type_code, chip_select_inputs, 1'b0};
	assign dr = dw | 8'h01;
	assign sda = !(sda_oe || sda_low);
	always #5 clk = !clk;
	serial_eeprom_rw_engine #(.program_cycles(600))
		serial_eeprom_rw_engine_inst (
		.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .busy(busy),
		.chip_select_inputs(chip_select_inputs),
		.write_protect(write_protect));
	ctl_model ctl_model_inst (.clk(clk), .sda(sda), .scl(scl),
		.sda_low(sda_low));
	// Compare and count
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	// Print counts and verdict
	task automatic give_verdict();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	// Write n bytes from d at address a, page wrap in model
	task automatic wr(logic [7:0] a, int n, logic [7:0] d);
		ctl_model_inst.start();
		ctl_model_inst.xfer(dw, 1'b1, q, k);
		chk("dev ack", k, 8'h00);
		ctl_model_inst.xfer(a, 1'b1, q, k);
		chk("word ack", k, 8'h00);
		for (int i = 0; i < n; i++) begin
			ctl_model_inst.xfer(d + 8'(i), 1'b1, q, k);
			chk("data ack", k, 8'h00);
			if (!write_protect)
				mem[a] = d + 8'(i);
			a[2:0] = a[2:0] + 3'h1;
		end
		ctl_model_inst.stop();
		if (!write_protect)
			cnt_e = a;
		@(negedge clk);
		chk("busy", busy, {7'h0, !write_protect});
	endtask : wr
	// Poll: first try lands in programming
	task automatic poll();
		k = 1'b1;
		for (int i = 0; i < 12 && k; i++) begin
			ctl_model_inst.start();
			ctl_model_inst.xfer(dw, 1'b1, q, k);
			if (i == 0)
				chk("poll nack", k, 8'h01);
			ctl_model_inst.stop();
		end
		chk("poll ack", k, 8'h00);
	endtask : poll
	// Optional dummy write, then n bytes, last one nacked
	task automatic rd(logic rnd, logic [7:0] a, int n);
		if (rnd) begin
			ctl_model_inst.start();
			ctl_model_inst.xfer(dw, 1'b1, q, k);
			ctl_model_inst.xfer(a, 1'b1, q, k);
			cnt_e = a;
		end
		ctl_model_inst.start();
		ctl_model_inst.xfer(dr, 1'b1, q, k);
		chk("rd ack", k, 8'h00);
		for (int i = 0; i < n; i++) begin
			ctl_model_inst.xfer(8'hff, i == n - 1, q, k);
			chk("rd data", q, mem[cnt_e]);
			cnt_e++;
		end
		ctl_model_inst.stop();
	endtask : rd
	// Cycle ceiling
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			give_verdict();
		end
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		wr(8'h10, 1, 8'h3c);
		poll();
		rd(1'b1, 8'h10, 1);
		wr(8'h1e, 9, 8'h40);
		poll();
		rd(1'b0, 8'h00, 1);
		rd(1'b1, 8'h18, 8);
		wr(8'hff, 1, 8'hee);
		poll();
		wr(8'h00, 1, 8'hdd);
		poll();
		rd(1'b1, 8'hff, 2);
		write_protect <= 1'b1;
		wr(8'h18, 1, 8'h00);
		write_protect <= 1'b0;
		rd(1'b1, 8'h18, 1);
		ctl_model_inst.start();
		ctl_model_inst.xfer({dev_type_code, 4'h4}, 1'b1, q, k);
		chk("cs nack", k, 8'h01);
		ctl_model_inst.stop();
		give_verdict();
	end
endmodule : serial_eeprom_rw_engine_tb
